// File: core/csri_defines.vh
`ifndef CSRI_DEFINES_VH
`define CSRI_DEFINES_VH

// ==========================================================
// Register indices
`define CSRI_IDX_BOOT_ARG 4'h0
`define CSRI_IDX_TICK 4'h1
`define CSRI_IDX_IN_LO 4'h2
`define CSRI_IDX_IN_HI 4'h3
`define CSRI_IDX_OUT_LO 4'h4
`define CSRI_IDX_OUT_HI 4'h5
`define CSRI_IDX_DIR_LO 4'h6
`define CSRI_IDX_DIR_HI 4'h7
`define CSRI_IDX_T1_CTRL 4'h8
`define CSRI_IDX_T2_CTRL 4'h9
`define CSRI_IDX_T1_INC 4'ha
`define CSRI_IDX_T2_INC 4'hb
`define CSRI_IDX_T1_ACC 4'hc
`define CSRI_IDX_T2_ACC 4'hd
`define CSRI_IDX_VID_SETUP 4'he
`define CSRI_IDX_VID_SCALE 4'hf

// ==========================================================
// Sizes and reset values
`define CSRI_NUM_REGS 16
`define CSRI_RST_WORD 32'h0000_0000

`endif

// File: core/csri_word_ram.v
`timescale 1ns/1ps
// ==========================================================
// Small word store for the counter and video set-up words
module csri_word_ram #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock
  input wire ref_clk_in,
  // Write side
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [WIDTH-1:0] wr_data_in,
  // Read side, registered data
  input wire [AW-1:0] rd_addr_in,
  output reg [WIDTH-1:0] rd_data_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write port; no reset so it maps to plain storage
  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read, write-first to hide the same-cycle hazard
  always @(posedge ref_clk_in) begin
    if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
      rd_data_out <= wr_data_in;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // csri_word_ram

// File: core/csri_special_regs.v
`timescale 1ns/1ps
`include "csri_defines.vh"
// ==========================================================
// Indexed special register bank of one core
module csri_special_regs #(
  parameter DW = 32,
  parameter IW = 4
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // Boot argument loaded at core start
  input wire boot_load_in,
  input wire [DW-1:0] boot_arg_in,
  // Pin inputs, low bank
  input wire [DW-1:0] pin_in_in,
  // Indexed access port
  input wire idx_rd_in,
  input wire idx_wr_in,
  input wire [IW-1:0] idx_in,
  input wire [DW-1:0] idx_wdata_in,
  output reg [DW-1:0] idx_rdata_out,
  output reg idx_rvalid_out,
  // Direct named view
  output reg [DW-1:0] pin_output_low_out,
  output reg [DW-1:0] pin_direction_low_out,
  output reg [DW-1:0] tick_out
);

  // ==========================================================
  // State
  reg [DW-1:0] boot_arg_r;
  reg [DW-1:0] tick_r;
  reg [DW-1:0] out_lo_r;
  reg [DW-1:0] dir_lo_r;
  reg rd_pend_r;
  reg rd_ram_r;
  reg [DW-1:0] rd_flop_r;
  wire [DW-1:0] ram_rdata;
  wire ram_wr;

  // Indices 8..15 live in the word store, others in flops
  function is_ram_idx;
    input [IW-1:0] idx;
    begin
      is_ram_idx = idx[3];
    end
  endfunction

  // ==========================================================
  // Boot argument: only the core start loads it, software cannot
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      boot_arg_r <= `CSRI_RST_WORD;
    end else if (boot_load_in) begin
      boot_arg_r <= boot_arg_in;
    end
  end

  // Free-running system counter, never written by index
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_r <= `CSRI_RST_WORD;
    end else begin
      tick_r <= tick_r + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Pin output and direction words, full 32-bit writes
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_lo_r <= `CSRI_RST_WORD;
      dir_lo_r <= `CSRI_RST_WORD;
    end else if (idx_wr_in) begin
      if (idx_in == `CSRI_IDX_OUT_LO) begin
        out_lo_r <= idx_wdata_in;
      end
      if (idx_in == `CSRI_IDX_DIR_LO) begin
        dir_lo_r <= idx_wdata_in;
      end
    end
  end

  // Counter and video words: indices 8 to 15, all writable
  assign ram_wr = idx_wr_in && is_ram_idx(idx_in);

  csri_word_ram #(
    .WIDTH(DW),
    .DEPTH(8),
    .AW(3)
  ) u_ram (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(ram_wr),
    .wr_addr_in(idx_in[2:0]),
    .wr_data_in(idx_wdata_in),
    .rd_addr_in(idx_in[2:0]),
    .rd_data_out(ram_rdata)
  );

  // ==========================================================
  // Read mux for flop-held entries; reserved and unknown read zero
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_flop_r <= `CSRI_RST_WORD;
      rd_pend_r <= 1'b0;
      rd_ram_r <= 1'b0;
    end else begin
      rd_pend_r <= idx_rd_in;
      rd_ram_r <= is_ram_idx(idx_in);
      case (idx_in)
        `CSRI_IDX_BOOT_ARG: rd_flop_r <= boot_arg_r;
        `CSRI_IDX_TICK: rd_flop_r <= tick_r;
        `CSRI_IDX_IN_LO: rd_flop_r <= pin_in_in;
        `CSRI_IDX_OUT_LO: rd_flop_r <= out_lo_r;
        `CSRI_IDX_DIR_LO: rd_flop_r <= dir_lo_r;
        // High bank kept for a future pin bank
        `CSRI_IDX_IN_HI, `CSRI_IDX_OUT_HI, `CSRI_IDX_DIR_HI: rd_flop_r <= `CSRI_RST_WORD;
        default: rd_flop_r <= `CSRI_RST_WORD;
      endcase
    end
  end

  // Read answer: second cycle, since the word store reads registered
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idx_rdata_out <= `CSRI_RST_WORD;
      idx_rvalid_out <= 1'b0;
    end else begin
      idx_rvalid_out <= rd_pend_r;
      if (rd_pend_r) begin
        idx_rdata_out <= rd_ram_r ? ram_rdata : rd_flop_r;
      end
    end
  end

  // Direct view is a registered copy of the index-path flops, one cycle behind them
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_output_low_out <= `CSRI_RST_WORD;
      pin_direction_low_out <= `CSRI_RST_WORD;
      tick_out <= `CSRI_RST_WORD;
    end else begin
      pin_output_low_out <= out_lo_r;
      pin_direction_low_out <= dir_lo_r;
      tick_out <= tick_r;
    end
  end

endmodule // csri_special_regs

// File: dv/csri_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Port checks for the special register bank
module csri_sva (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // Access port
  input wire idx_rd_in,
  input wire idx_wr_in,
  input wire [3:0] idx_in,
  input wire [31:0] idx_wdata_in,
  input wire [31:0] idx_rdata_out,
  input wire idx_rvalid_out,
  // Named view
  input wire [31:0] pin_output_low_out,
  input wire [31:0] pin_direction_low_out,
  input wire [31:0] tick_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Answer lands two edges after the take
  sequence s_answer; ##2 idx_rvalid_out; endsequence
  sequence s_zero; ##2 idx_rdata_out == 32'h0000_0000; endsequence
  wire out_wr = idx_wr_in && idx_in == 4'h4;
  a_read_answer: assert property (idx_rd_in |-> s_answer) else $error("late answer");
  a_no_stray: assert property (idx_rvalid_out |-> $past(idx_rd_in, 2)) else $error("stray answer");
  a_rsvd_zero: assert property (idx_rd_in && idx_in[0] && idx_in < 4'h8 && idx_in > 4'h2 |-> s_zero)
    else $error("reserved not zero");
  a_out_load: assert property (out_wr |-> ##2 pin_output_low_out == $past(idx_wdata_in, 2))
    else $error("out word");
  a_out_hold: assert property (!out_wr |-> ##2 $stable(pin_output_low_out)) else $error("out disturbed");
  a_dir_load: assert property (idx_wr_in && idx_in == 4'h6 |-> ##2 pin_direction_low_out == $past(idx_wdata_in, 2))
    else $error("dir word");
  a_tick_step: assert property (tick_out != 0 |=> tick_out == $past(tick_out) + 32'h0000_0001)
    else $error("tick step");
  a_rdata_stands: assert property ($changed(idx_rdata_out) |-> idx_rvalid_out) else $error("data moved");
endmodule // csri_sva
bind csri_special_regs csri_sva chk_u (.ref_clk_in, .reset_in, .idx_rd_in, .idx_wr_in, .idx_in, .idx_wdata_in,
  .idx_rdata_out, .idx_rvalid_out, .pin_output_low_out, .pin_direction_low_out, .tick_out);

// File: dv/core_special_register_index_test.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the special register bank
module core_special_register_index_test;
  reg ref_clk_in = 0;
  reg reset_in = 1;
  reg bl = 0, rd = 0, wr = 0;
  reg [3:0] ix = 0;
  reg [31:0] ba = 0, pin = 0, wd = 0, got, t1;
  wire [31:0] rdat, po, pd, tk;
  wire rv;
  integer fails = 0, cmp_count = 0, cyc = 0, tt, ta, j;
  // Clock and a cycle count for counter checks
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) cyc <= cyc + 1;
  csri_special_regs dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .boot_load_in(bl), .boot_arg_in(ba),
    .pin_in_in(pin), .idx_rd_in(rd), .idx_wr_in(wr), .idx_in(ix), .idx_wdata_in(wd), .idx_rdata_out(rdat),
    .idx_rvalid_out(rv), .pin_output_low_out(po), .pin_direction_low_out(pd), .tick_out(tk));
  // Word compare and closing report
  task chk(input [31:0] g, input [31:0] e); begin
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task tally_and_finish; begin
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  end endtask
  // One-cycle requests; a read waits a bounded time for its answer
  task wr_w(input [3:0] i, input [31:0] d); begin
    @(negedge ref_clk_in); wr = 1; ix = i; wd = d;
    @(negedge ref_clk_in); wr = 0;
  end endtask
  task rd_w(input [3:0] i); integer k; begin
    @(negedge ref_clk_in); rd = 1; ix = i; tt = cyc;
    @(negedge ref_clk_in); rd = 0; k = 0;
    while (rv !== 1'b1 && k < 4) begin @(negedge ref_clk_in); k = k + 1; end
    if (rv !== 1'b1) begin
      fails = fails + 1;
      $display("[ERR] %0t read answer timed out", $time);
      tally_and_finish;
    end
    else got = rdat;
  end endtask
  task t_pins; begin
    wr_w(4, 32'h0000_00ca); wr_w(6, 32'h5a5a_0f0f); rd_w(4);
    chk(got, 32'h0000_00ca);
    chk(po, 32'h0000_00ca);
    rd_w(6); chk(got, 32'h5a5a_0f0f);
    chk(pd, 32'h5a5a_0f0f);
    $display("pins done");
  end endtask
  task t_input; begin
    pin = 32'h1234_5678; wr_w(2, 32'h0000_0000); rd_w(2);
    chk(got, 32'h1234_5678);
    $display("input done");
  end endtask
  task t_rsvd; begin
    for (j = 3; j < 8; j = j + 2) begin wr_w(j, 32'hffff_ffff); rd_w(j); chk(got, 32'h0000_0000); end
    chk(po, 32'h0000_00ca);
    $display("reserved done");
  end endtask
  task t_boot; begin
    @(negedge ref_clk_in); bl = 1; ba = 32'h0000_00a5;
    @(negedge ref_clk_in); bl = 0;
    wr_w(0, 32'hffff_ffff); rd_w(0); chk(got, 32'h0000_00a5);
    $display("boot done");
  end endtask
  task t_array; begin
    for (j = 8; j < 16; j = j + 1) wr_w(j, 32'ha5a5_0000 | j);
    for (j = 8; j < 16; j = j + 1) begin rd_w(j); chk(got, 32'ha5a5_0000 | j); end
    $display("array done");
  end endtask
  task t_tick; begin
    rd_w(1); t1 = got; ta = tt; wr_w(1, 32'h0000_0000); rd_w(1);
    chk(got - t1, tt - ta);
    // Named counter view is one tick ahead of the word read at the take edge
    chk(tk - got, 32'h0000_0001);
    $display("tick done");
  end endtask
  // Reset, then the scenarios
  initial begin
    repeat (20) @(negedge ref_clk_in);
    reset_in = 0;
    t_pins; t_input; t_rsvd; t_boot; t_array; t_tick;
    tally_and_finish;
  end
endmodule // core_special_register_index_test
